// ---- logic/pas_adc_map.svh ----
// Constant map for the pipelined converter sample path
`ifndef PAS_ADC_MAP_SVH
`define PAS_ADC_MAP_SVH
`define PAS_WORD_W 11
`define PAS_SUM_W 12
`define PAS_CODE_W 2
`define PAS_NUM_STAGES 10
`define PAS_FLASH_IDX 10
`define PAS_CODES_W 22
`define PAS_STEPS 12
`define PAS_LATENCY_CYC 6
`define PAS_FIFO_DEPTH 8
`define PAS_CNT_W 16
`define PAS_WORD_RST 11'h000
`define PAS_WORD_MAX 11'h3FF
`define PAS_WORD_MIN 11'h400
`define PAS_SUM_MAX 12'sh3FF
`define PAS_SUM_MIN -12'sh400
`endif

// ---- logic/pas_pkg.sv ----
// Shared types for the pipelined converter sample path
`include "pas_adc_map.svh"
package pas_pkg;
  typedef logic [`PAS_WORD_W-1:0] pas_word_t;     // Two's complement output word
  typedef logic [`PAS_CODES_W-1:0] pas_codes_t;   // Ten stage codes plus flash code
  typedef logic signed [`PAS_SUM_W-1:0] pas_sum_t; // Partial combined result
  typedef logic [`PAS_CNT_W-1:0] pas_cnt_t;       // Clock period counter
endpackage

// ---- logic/pas_fifo.sv ----
// Parameterised synchronous FIFO with valid and ready on both sides
module pas_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH]; // Word storage
  logic [AW-1:0] wrPtr_r, wrPtr_nxt;
  logic [AW-1:0] rdPtr_r, rdPtr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count
  assign inReady = (count_r != FULL_CNT);
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Next pointers and occupancy
  always_comb begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (flush) begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
      count_nxt = '0;
    end else begin
      if (push) begin
        wrPtr_nxt = (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_nxt = (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + 1'b1;
      end
      if (push && !pop) begin
        count_nxt = count_r + 1'b1;
      end else if (pop && !push) begin
        count_nxt = count_r - 1'b1;
      end
    end
  end

  // Register state; storage written on accepted pushes
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
    if (push && !flush) begin
      mem[wrPtr_r] <= inData;
    end
  end
endmodule // pas_fifo

// ---- logic/pas_adc_top.sv ----
// Digital side of the pipelined converter: stage combine, latency pipeline, output
// Functional notes
// R1 - 11-bit word, top line is MSB
// R2 - Word appears six conversion cycles after sampling
// R3 - Pipeline advances on both conversion clock edges
// R4 - Ten 1.5-bit stages plus flash combined
// R5 - Duty cycle correction on when input high
// R6 - Power-down input high stops conversion
// R7 - Reference select high chooses external reference
// R8 - Output words are two's complement
// R9 - Capture ignores words during power-down and refill
`include "pas_adc_map.svh"
module pas_adc_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic convClkPin,
  input wire pas_pkg::pas_codes_t stageCodesPin,
  input wire logic powerDownPin,
  input wire logic dutyCycleAdjustEn,
  input wire logic refSelectPin,
  input wire logic captureReady,
  output pas_pkg::pas_word_t sampleDataBus,
  output logic sampleValid,
  output logic overrun,
  output logic poweredDown,
  output logic dcaActive,
  output logic refExternal
);
  import pas_pkg::*;

  // Two-flop synchronisers for every pin except captureReady; a third clock flop for edges
  logic clkS1_r, clkS2_r, clkS3_r;
  pas_codes_t codeS1_r, codeS2_r;
  logic [2:0] strapS1_r, strapS2_r; // Power-down, duty adjust, reference select
  logic pdOn;
  logic dcaOn;
  logic riseEvt;
  logic fallEvt;
  logic halfEvt;

  // Duty cycle correction timing
  pas_cnt_t sinceRise_r, sinceRise_nxt;
  pas_cnt_t halfPer_r, halfPer_nxt;

  // Half-step pipeline entries; entry s holds the sum of codes 0..s-1
  logic [`PAS_STEPS-1:0] stepValid_r, stepValid_nxt;
  pas_sum_t stepSum_r [`PAS_STEPS];
  pas_sum_t stepSum_nxt [`PAS_STEPS];
  pas_codes_t stepCodes_r [`PAS_STEPS];
  pas_codes_t stepCodes_nxt [`PAS_STEPS];

  // FIFO link and output stage
  logic pushValid;
  pas_word_t pushWord;
  logic fifoInReady;
  logic fifoOutValid;
  pas_word_t fifoOutData;
  logic fifoPop;
  pas_word_t dataOut_r, dataOut_nxt;
  logic validOut_r, validOut_nxt;
  logic overrun_r, overrun_nxt;
  logic [2:0] strapOut_r;

  // Weight of one resolved code: stage codes 0..2 mean -1..+1, flash 0..3 means -2..+1
  function automatic pas_sum_t stepWeight(input logic [3:0] idx, input logic [1:0] code);
    pas_sum_t d;
    d = pas_sum_t'(code);
    if (idx == 4'(`PAS_FLASH_IDX)) begin
      d = d - 12'sd2;
    end else begin
      d = (d - 12'sd1) <<< (4'd9 - idx);
    end
    return d;
  endfunction

  // Clip the redundant range into the signed output word
  function automatic pas_word_t clipWord(input pas_sum_t s);
    pas_word_t w;
    if (s > `PAS_SUM_MAX) begin
      w = `PAS_WORD_MAX;
    end else if (s < `PAS_SUM_MIN) begin
      w = `PAS_WORD_MIN;
    end else begin
      w = s[`PAS_WORD_W-1:0]; // [R8]
    end
    return w;
  endfunction

  // Synchroniser and edge-history flops
  // Clock history keeps tracking the pin through reset, so a clock that is high
  // when reset ends is not mistaken for a fresh rising edge
  always_ff @(posedge sys_clk) begin
    clkS1_r <= convClkPin;
    clkS2_r <= clkS1_r;
    clkS3_r <= clkS2_r;
    if (sys_rst) begin
      codeS1_r <= '0;
      codeS2_r <= '0;
      strapS1_r <= 3'h0;
      strapS2_r <= 3'h0;
    end else begin
      codeS1_r <= stageCodesPin;
      codeS2_r <= codeS1_r;
      strapS1_r <= {refSelectPin, dutyCycleAdjustEn, powerDownPin};
      strapS2_r <= strapS1_r;
    end
  end

  assign pdOn = strapS2_r[0]; // [R6]
  assign dcaOn = strapS2_r[1]; // [R5]
  assign riseEvt = clkS2_r && !clkS3_r;
  // With correction on, the second half-step sits at mid-period, not on the raw edge
  assign fallEvt = dcaOn ? ((halfPer_r != '0) && (sinceRise_r == halfPer_r))
                         : (!clkS2_r && clkS3_r); // [R5]
  assign halfEvt = riseEvt || fallEvt; // [R3]

  // Period measurement for duty cycle correction
  always_comb begin
    sinceRise_nxt = (sinceRise_r == '1) ? sinceRise_r : sinceRise_r + 1'b1;
    halfPer_nxt = halfPer_r;
    if (riseEvt) begin
      sinceRise_nxt = 16'h0001;
      halfPer_nxt = sinceRise_r >> 1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sinceRise_r <= 16'h0000;
      halfPer_r <= 16'h0000;
    end else begin
      sinceRise_r <= sinceRise_nxt;
      halfPer_r <= halfPer_nxt;
    end
  end

  // Shift one half-step per clock edge, resolving one code per step
  always_comb begin
    stepValid_nxt = stepValid_r;
    stepSum_nxt = stepSum_r;
    stepCodes_nxt = stepCodes_r;
    if (pdOn) begin
      stepValid_nxt = '0; // [R6]
    end else if (halfEvt) begin
      for (int s = `PAS_STEPS - 1; s > 0; s--) begin
        stepValid_nxt[s] = stepValid_r[s-1]; // [R3]
        stepCodes_nxt[s] = stepCodes_r[s-1];
        stepSum_nxt[s] = stepSum_r[s-1]
          + stepWeight(4'(s - 1), stepCodes_r[s-1][2*(s-1) +: `PAS_CODE_W]); // [R4]
      end
      stepValid_nxt[0] = riseEvt; // New sample only on the rising edge
      stepSum_nxt[0] = '0;
      stepCodes_nxt[0] = codeS2_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stepValid_r <= '0;
      for (int s = 0; s < `PAS_STEPS; s++) begin
        stepSum_r[s] <= '0;
        stepCodes_r[s] <= '0;
      end
    end else begin
      stepValid_r <= stepValid_nxt;
      stepSum_r <= stepSum_nxt;
      stepCodes_r <= stepCodes_nxt;
    end
  end

  // Twelfth half-step after sampling lands on the sixth rising edge
  assign pushValid = halfEvt && stepValid_r[`PAS_STEPS-1] && !pdOn; // [R2]
  assign pushWord = clipWord(stepSum_r[`PAS_STEPS-1]); // [R4]

  pas_fifo #(
    .WIDTH(`PAS_WORD_W),
    .DEPTH(`PAS_FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst(sys_rst),
    .flush(pdOn),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(pushWord),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  // Output stage refills when empty or when capture takes the word
  assign fifoPop = !pdOn && (!validOut_r || captureReady);

  always_comb begin
    dataOut_nxt = dataOut_r;
    validOut_nxt = validOut_r;
    overrun_nxt = overrun_r;
    if (pdOn) begin
      dataOut_nxt = `PAS_WORD_RST; // [R6]
      validOut_nxt = 1'b0;
    end else if (fifoPop) begin
      validOut_nxt = fifoOutValid;
      if (fifoOutValid) begin
        dataOut_nxt = fifoOutData; // [R1]
      end
    end
    // A converter cannot wait, so a full buffer loses the word and flags it
    if (pushValid && !fifoInReady) begin
      overrun_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dataOut_r <= `PAS_WORD_RST;
      validOut_r <= 1'b0;
      overrun_r <= 1'b0;
      strapOut_r <= 3'h0;
    end else begin
      dataOut_r <= dataOut_nxt;
      validOut_r <= validOut_nxt;
      overrun_r <= overrun_nxt;
      strapOut_r <= strapS2_r;
    end
  end

  assign sampleDataBus = dataOut_r; // [R1]
  assign sampleValid = validOut_r; // [R9]
  assign overrun = overrun_r;
  assign poweredDown = strapOut_r[0];
  assign dcaActive = strapOut_r[1];
  assign refExternal = strapOut_r[2]; // [R7]
endmodule // pas_adc_top

// ---- dv/pas_adc_assertions.sv ----
// Port checker for the converter sample path, bound to the top module
module pas_adc_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic convClkPin,
  input wire logic powerDownPin,
  input wire logic dutyCycleAdjustEn,
  input wire logic refSelectPin,
  input wire logic captureReady,
  input wire pas_pkg::pas_word_t sampleDataBus,
  input wire logic sampleValid,
  input wire logic overrun,
  input wire logic poweredDown,
  input wire logic dcaActive,
  input wire logic refExternal
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] upCnt; // Edges since reset, stops at 4 once strap syncs are filled
  logic [3:0] riseCnt; // Conversion rises since reset or power-down
  logic convPrev; // Last sampled conversion clock level
  // Helper counters; rise count restarts whenever the pipeline is emptied
  always_ff @(posedge sys_clk) begin
    convPrev <= convClkPin;
    upCnt <= sys_rst ? 3'h0 : (upCnt == 3'h4 ? upCnt : upCnt + 3'h1);
    if (sys_rst || poweredDown) begin
      riseCnt <= 4'h0;
    end else if (convClkPin && !convPrev && riseCnt != 4'hF) begin
      riseCnt <= riseCnt + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_rst; $fell(sys_rst) |-> !sampleValid && !overrun && sampleDataBus == 11'h000;
  endproperty
  property p_hold; sampleValid && !captureReady && !powerDownPin |=>
    sampleValid && $stable(sampleDataBus); endproperty
  property p_lat; sampleValid |-> riseCnt > 4'h6; endproperty
  property p_pdclr; poweredDown [*2] |-> !sampleValid; endproperty
  property p_pd; upCnt == 3'h4 |-> poweredDown == $past(powerDownPin, 3); endproperty
  property p_dca; upCnt == 3'h4 |-> dcaActive == $past(dutyCycleAdjustEn, 3); endproperty
  property p_ref; upCnt == 3'h4 |-> refExternal == $past(refSelectPin, 3); endproperty
  property p_ovr; overrun |=> overrun; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_hold: assert property (p_hold) else $error("word changed while stalled");
  a_lat: assert property (p_lat) else $error("word before six cycle latency");
  a_pdclr: assert property (p_pdclr) else $error("word during power-down");
  a_pd: assert property (p_pd) else $error("power-down copy wrong");
  a_dca: assert property (p_dca) else $error("duty adjust copy wrong");
  a_ref: assert property (p_ref) else $error("reference copy wrong");
  a_ovr: assert property (p_ovr) else $error("overrun flag lost");
  c_stall: cover property (sampleValid && !captureReady);
  c_ovr: cover property ($rose(overrun));
  c_pd: cover property ($rose(poweredDown));
endmodule // pas_adc_checker

bind pas_adc_top pas_adc_checker pas_adc_checker_inst (.sys_clk, .sys_rst, .convClkPin,
  .powerDownPin, .dutyCycleAdjustEn, .refSelectPin, .captureReady, .sampleDataBus,
  .sampleValid, .overrun, .poweredDown, .dcaActive, .refExternal);

// ---- dv/pas_capture_model.sv ----
// Capture-side model that registers sample words, fast, slow or stalled
module pas_capture_model (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic slow,
  input wire logic poweredDown,
  input wire logic sampleValid,
  input wire pas_pkg::pas_word_t sampleDataBus,
  output logic captureReady,
  output logic gotWord,
  output pas_pkg::pas_word_t capWord
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tick = 1'b0; // Alternates so a slow consumer takes every other cycle
  always @(posedge sys_clk) tick <= ~tick;
  assign captureReady = !stall && (!slow || tick);
  // Register each taken word; words during power-down are discarded
  always @(posedge sys_clk) begin
    gotWord <= sampleValid && captureReady && !poweredDown;
    capWord <= sampleDataBus;
  end
endmodule // pas_capture_model

// ---- dv/pas_adc_top_tb.sv ----
// Self-checking bench for the converter sample path
module pas_adc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pas_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, convClkPin = 1'b0, powerDownPin = 1'b0;
  logic dca = 1'b0, refSel = 1'b0, stall = 1'b0, slow = 1'b0;
  logic captureReady, sampleValid, overrun, poweredDown, dcaActive, refExternal, gotWord;
  pas_codes_t codes = 22'h255555, nextCodes = 22'h255555;
  pas_word_t sampleDataBus, capWord;
  pas_word_t expQ[$]; // Expected words in sampling order
  pas_codes_t tab[6] = '{22'h000000, 22'h2AAAAA, 22'h3AAAAA, 22'h255555, 22'h155556, 22'h195555};
  int num_errors = 0, check_count = 0;
  always #5 sys_clk = ~sys_clk;
  pas_adc_top pas_adc_top_inst (.sys_clk, .sys_rst, .convClkPin, .stageCodesPin(codes),
    .powerDownPin, .dutyCycleAdjustEn(dca), .refSelectPin(refSel), .captureReady,
    .sampleDataBus, .sampleValid, .overrun, .poweredDown, .dcaActive, .refExternal);
  pas_capture_model pas_capture_model_inst (.sys_clk, .stall, .slow, .poweredDown,
    .sampleValid, .sampleDataBus, .captureReady, .gotWord, .capWord);
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(string n, pas_word_t s, pas_word_t e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  // Weighted sum of stage codes, clipped to the signed word range
  function automatic pas_word_t expWord(pas_codes_t c);
    int s;
    s = int'(c[21:20]) - 2;
    for (int i = 0; i < 10; i++) s += (int'(c[2*i+:2]) - 1) << (9 - i);
    if (s > 1023) s = 1023;
    if (s < -1024) s = -1024;
    return s[10:0];
  endfunction
  // Free-running conversion clock, 10 system cycles a period
  initial begin
    step(4);
    forever begin
      codes = nextCodes;
      step(5);
      convClkPin = 1'b1;
      if (!sys_rst && !powerDownPin) expQ.push_back(expWord(codes));
      step(5);
      convClkPin = 1'b0;
    end
  end
  // Every captured word is compared in order
  always @(posedge sys_clk) begin
    if (!sys_rst && gotWord !== 1'b0) chk("word", capWord, expQ.pop_front());
  end
  // First word stands for one cycle only, so look just before and just after it lands
  task automatic t_latency();
    step(68);
    chk("early valid", sampleValid, 0);
    step(1);
    chk("first valid", sampleValid, 1);
    step(5);
  endtask
  // Start just after a conversion rise so the pending count does not depend on phase
  task automatic t_stream(logic on);
    @(posedge convClkPin);
    step(1);
    dca = on;
    refSel = on;
    slow = on;
    foreach (tab[i]) begin
      nextCodes = tab[i];
      step(10);
    end
    step(65);
    chk("dca", dcaActive, on);
    chk("ref", refExternal, on);
    chk("pending", expQ.size(), 6);
  endtask
  // Power-down set and cleared one system cycle after a conversion rise; refill timed from the first rise after
  task automatic t_powerdown();
    dca = 1'b0;
    @(posedge convClkPin);
    step(1);
    powerDownPin = 1'b1;
    step(30);
    chk("pd", poweredDown, 1);
    chk("pd valid", sampleValid, 0);
    expQ.delete();
    powerDownPin = 1'b0;
    @(posedge convClkPin);
    step(63);
    chk("refill", sampleValid, 0);
    step(1);
    chk("resume", sampleValid, 1);
    step(5);
  endtask
  task automatic t_overrun();
    stall = 1'b1;
    step(165);
    chk("overrun", overrun, 1);
    chk("held", sampleValid, 1);
    sys_rst = 1'b1;
    expQ.delete();
    step(10);
    sys_rst = 1'b0;
    stall = 1'b0;
    chk("rst ovr", overrun, 0);
    chk("rst valid", sampleValid, 0);
    step(100);
  endtask
  task automatic end_sim();
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    step(4);
    sys_rst = 1'b0;
    t_latency();
    t_stream(1'b0);
    t_stream(1'b1);
    t_powerdown();
    t_overrun();
    end_sim();
  end
  // Watchdog: about three and a half times the expected run
  initial begin
    #25000;
    num_errors++;
    end_sim();
  end
endmodule // pas_adc_top_tb
